/* common/ifsub_defs.svh */
// Constants of the IF counter select and sub PLL divider block.
// Assumes a 100 MHz core clock; included by the package, the link and top design files and the sim files.
`ifndef IFSUB_DEFS_SVH
`define IFSUB_DEFS_SVH

// Core clock rate in kHz
`define IFSUB_CLK_KHZ 100000
// Gate periods in ms and their cycle counts
`define IFSUB_GATE0_MS 4
`define IFSUB_GATE1_MS 8
`define IFSUB_GATE2_MS 32
`define IFSUB_GATE3_MS 64
`define IFSUB_GATE0_CYC (`IFSUB_GATE0_MS * `IFSUB_CLK_KHZ)
`define IFSUB_GATE1_CYC (`IFSUB_GATE1_MS * `IFSUB_CLK_KHZ)
`define IFSUB_GATE2_CYC (`IFSUB_GATE2_MS * `IFSUB_CLK_KHZ)
`define IFSUB_GATE3_CYC (`IFSUB_GATE3_MS * `IFSUB_CLK_KHZ)
// Input frequency ceilings in kHz
`define IFSUB_RANGE_LO_KHZ 12000
`define IFSUB_RANGE_HI_KHZ 25000
// Swallow divisor floor
`define IFSUB_SUB_DIV_MIN 13'h0110
// Widths
`define IFSUB_CNT_W 21
`define IFSUB_WORD_W 24
`define IFSUB_GATE_W 23
`define IFSUB_DIV_W 13
// Output content codes
`define IFSUB_DOC_COUNT 3'h0
`define IFSUB_DOC_PORT 3'h1
`endif

/* common/ifsub_pkg.sv */
// Types of the IF counter select and sub PLL divider block.
// Assumes ifsub_defs.svh for all widths.
`include "ifsub_defs.svh"

package ifsub_pkg;
  // Measurement sequence, one bit changes per step except from DONE back to IDLE
  typedef enum logic [1:0] {
    IFSUB_IDLE = 2'h0,
    IFSUB_RUN = 2'h1,
    IFSUB_DONE = 2'h3
  } ifsub_state_t;

  // Control bits from the serial control data
  typedef struct packed {
    logic counter_input_select;
    logic if_range_select;
    logic second_input_function;
    logic [1:0] gate_select;
    logic [2:0] output_content_select;
    logic sub_divider_enable;
    logic [`IFSUB_DIV_W-1:0] sub_divisor;
  } ifsub_ctrl_t;

  // Two-flop synchroniser state
  typedef struct packed {
    logic meta;
    logic stable;
  } ifsub_sync_t;

  // Link-side state
  typedef struct packed {
    logic req_seen;
    logic frame;
    logic sdata;
    logic [`IFSUB_WORD_W-1:0] word;
    logic [`IFSUB_WORD_W-1:0] shift;
  } ifsub_link_t;

  // Core-side state
  typedef struct packed {
    ifsub_state_t st;
    logic [`IFSUB_GATE_W-1:0] gate_cnt;
    logic [`IFSUB_CNT_W-1:0] if_cnt;
    logic [`IFSUB_CNT_W-1:0] result;
    logic over;
    logic done;
    logic src_q;
    logic lo_q;
    logic ref_q;
    logic presc;
    logic [`IFSUB_DIV_W-1:0] sw_cnt;
    logic up;
    logic dn;
    logic cp_out;
    logic cp_oe_n;
    logic req;
    logic [`IFSUB_WORD_W-1:0] word;
  } ifsub_core_t;
endpackage : ifsub_pkg

/* logic/ifsub_sync.sv */
// Two-flop synchroniser for one level.
// Assumes the input is asynchronous to i_clk.
`timescale 1ns/1ns

module ifsub_sync (
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_en,
  // Level in and out
  input wire logic i_async,
  output logic o_sync
);
  ifsub_pkg::ifsub_sync_t r;
  ifsub_pkg::ifsub_sync_t r_nxt;

  // Meta flop feeds only the stable flop
  always_comb begin
    r_nxt = r;
    if (i_en) begin
      r_nxt.meta = i_async;
      r_nxt.stable = r.meta;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_sync = r.stable;
endmodule : ifsub_sync

/* logic/ifsub_link.sv */
// Serial output shifter on the controller's serial clock.
// Assumes the word is held stable from a request toggle until acknowledged.
`timescale 1ns/1ns
`include "ifsub_defs.svh"

module ifsub_link (
  // Serial clock from the controller and core reset
  input wire logic i_serial_clock,
  input wire logic i_reset_n,
  // Read frame from the controller, same clock
  input wire logic i_read_enable,
  output logic o_serial_data,
  // Word handshake from the core domain
  input wire logic [`IFSUB_WORD_W-1:0] i_word,
  input wire logic i_req_toggle,
  output logic o_ack_toggle
);
  ifsub_pkg::ifsub_link_t r;
  ifsub_pkg::ifsub_link_t r_nxt;
  logic rst_n;
  logic req_sync;

  // Reset and request toggle brought onto the serial clock
  ifsub_sync u_rst (.i_clk(i_serial_clock), .i_reset_n(1'b1), .i_en(1'b1),
    .i_async(i_reset_n), .o_sync(rst_n));
  ifsub_sync u_req (.i_clk(i_serial_clock), .i_reset_n(rst_n), .i_en(1'b1),
    .i_async(i_req_toggle), .o_sync(req_sync));

  // Capture new words, shift the held word MSB first during a frame
  always_comb begin
    r_nxt = r;
    if (req_sync != r.req_seen) begin
      r_nxt.word = i_word;
      r_nxt.req_seen = req_sync;
    end
    r_nxt.frame = i_read_enable;
    if (i_read_enable && !r.frame) begin
      r_nxt.sdata = r.word[`IFSUB_WORD_W-1];
      r_nxt.shift = {r.word[`IFSUB_WORD_W-2:0], 1'b0};
    end else if (i_read_enable) begin
      r_nxt.sdata = r.shift[`IFSUB_WORD_W-1];
      r_nxt.shift = {r.shift[`IFSUB_WORD_W-2:0], 1'b0};
    end else begin
      r_nxt.sdata = 1'b0;
    end
  end

  // State register
  always_ff @(posedge i_serial_clock) begin
    if (!rst_n) begin
      r <= '0;
    end else begin
      r <= r_nxt;
    end
  end

  assign o_serial_data = r.sdata;
  assign o_ack_toggle = r.req_seen;
endmodule : ifsub_link

/* logic/ifsub_top.sv */
// IF counter input select, gate timing and result path, plus the sub PLL
// prescaler, swallow counter and charge pump.
// Assumes control bits are steady core-clock levels and that the pins
// i_if_input_a, i_if_input_b_or_port, i_sub_lo_input and i_sub_reference
// are asynchronous. The serial output runs on the controller's clock.
`timescale 1ns/1ns
`include "ifsub_defs.svh"

module ifsub_top #(
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE0_CYC = `IFSUB_GATE_W'(`IFSUB_GATE0_CYC),
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE1_CYC = `IFSUB_GATE_W'(`IFSUB_GATE1_CYC),
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE2_CYC = `IFSUB_GATE_W'(`IFSUB_GATE2_CYC),
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE3_CYC = `IFSUB_GATE_W'(`IFSUB_GATE3_CYC)
) (
  // Core clock, reset, enable
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  // Control bits
  input wire ifsub_pkg::ifsub_ctrl_t i_ctrl,
  input wire logic i_count_start,
  // Serial link
  input wire logic i_serial_clock,
  input wire logic i_read_enable,
  output logic o_serial_data,
  // IF counter pins
  input wire logic i_if_input_a,
  input wire logic i_if_input_b_or_port,
  // Sub PLL pins
  input wire logic i_sub_lo_input,
  input wire logic i_sub_reference,
  output logic o_sub_lo_pulldown,
  output logic o_sub_charge_pump_out,
  output logic o_sub_charge_pump_oe_n,
  // Status
  output logic o_count_busy,
  output logic o_count_done,
  output logic o_count_over,
  output logic [`IFSUB_CNT_W-1:0] o_count_result
);
  ifsub_pkg::ifsub_core_t r;
  ifsub_pkg::ifsub_core_t r_nxt;

  // Synchronised pin levels
  logic a_s;
  logic b_s;
  logic lo_s;
  logic ref_s;
  logic ack_s;
  // Acknowledge toggle from the serial clock side
  logic ack_toggle;

  // Derived terms
  logic use_b;
  logic src;
  logic src_rise;
  logic lo_gated;
  logic lo_rise;
  logic pre_rise;
  logic div_pulse;
  logic ref_rise;
  logic [`IFSUB_DIV_W-1:0] div_eff;

  // Gate period in ms for a select code
  function automatic logic [6:0] gate_ms(input logic [1:0] sel);
    logic [6:0] ms;
    ms = 7'(`IFSUB_GATE0_MS);
    if (sel == 2'h1) begin
      ms = 7'(`IFSUB_GATE1_MS);
    end else if (sel == 2'h2) begin
      ms = 7'(`IFSUB_GATE2_MS);
    end else if (sel == 2'h3) begin
      ms = 7'(`IFSUB_GATE3_MS);
    end
    return ms;
  endfunction : gate_ms

  // Highest legal count for the gate period and frequency range
  function automatic logic [`IFSUB_CNT_W-1:0] count_limit(input logic [1:0] sel,
                                                          input logic range);
    logic [21:0] prod;
    if (range) begin
      prod = 22'(gate_ms(sel)) * 22'(`IFSUB_RANGE_HI_KHZ);
    end else begin
      prod = 22'(gate_ms(sel)) * 22'(`IFSUB_RANGE_LO_KHZ);
    end
    return prod[`IFSUB_CNT_W-1:0];
  endfunction : count_limit

  // Gate length in core cycles for a select code
  function automatic logic [`IFSUB_GATE_W-1:0] gate_cycles(input logic [1:0] sel);
    logic [`IFSUB_GATE_W-1:0] cyc;
    cyc = P_GATE0_CYC;
    if (sel == 2'h1) begin
      cyc = P_GATE1_CYC;
    end else if (sel == 2'h2) begin
      cyc = P_GATE2_CYC;
    end else if (sel == 2'h3) begin
      cyc = P_GATE3_CYC;
    end
    return cyc;
  endfunction : gate_cycles

  // Swallow divisor with the floor applied
  function automatic logic [`IFSUB_DIV_W-1:0] clamp_div(
    input logic [`IFSUB_DIV_W-1:0] d);
    return (d < `IFSUB_SUB_DIV_MIN) ? `IFSUB_SUB_DIV_MIN : d;
  endfunction : clamp_div

  // Word for the serial output
  function automatic logic [`IFSUB_WORD_W-1:0] make_word(
    input logic [2:0] doc,
    input logic func,
    input logic level,
    input logic over,
    input logic [`IFSUB_CNT_W-1:0] res);
    logic [`IFSUB_WORD_W-1:0] w;
    w = '0;
    if (doc == `IFSUB_DOC_COUNT && func) begin
      w = {2'h0, over, res};
    end else if (doc == `IFSUB_DOC_COUNT || doc == `IFSUB_DOC_PORT) begin
      w[`IFSUB_WORD_W-1] = level;
    end
    return w;
  endfunction : make_word

  // Pin synchronisers on the core clock
  ifsub_sync u_sync_a (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_en(i_clk_en),
    .i_async(i_if_input_a), .o_sync(a_s));
  ifsub_sync u_sync_b (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_en(i_clk_en),
    .i_async(i_if_input_b_or_port), .o_sync(b_s));
  ifsub_sync u_sync_lo (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_en(i_clk_en),
    .i_async(lo_gated), .o_sync(lo_s));
  ifsub_sync u_sync_ref (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_en(i_clk_en),
    .i_async(i_sub_reference), .o_sync(ref_s));
  ifsub_sync u_sync_ack (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_en(i_clk_en),
    .i_async(ack_toggle), .o_sync(ack_s));

  // Serial output on the controller's clock
  ifsub_link u_link (
    .i_serial_clock(i_serial_clock),
    .i_reset_n(i_reset_n),
    .i_read_enable(i_read_enable),
    .o_serial_data(o_serial_data),
    .i_word(r.word),
    .i_req_toggle(r.req),
    .o_ack_toggle(ack_toggle)
  );

  // IF counter source select
  assign use_b = i_ctrl.counter_input_select & i_ctrl.second_input_function;
  assign src = use_b ? b_s : a_s;
  assign src_rise = src & ~r.src_q;

  // Sub LO input stopped while the divider is off
  assign lo_gated = i_sub_lo_input & i_ctrl.sub_divider_enable;
  assign lo_rise = lo_s & ~r.lo_q;
  assign pre_rise = lo_rise & ~r.presc;
  assign div_eff = clamp_div(i_ctrl.sub_divisor);
  assign div_pulse = pre_rise && (r.sw_cnt == div_eff - 13'h0001);
  assign ref_rise = ref_s & ~r.ref_q;

  // Next state of the core
  always_comb begin
    r_nxt = r;
    r_nxt.src_q = src;
    r_nxt.lo_q = lo_s;
    r_nxt.ref_q = ref_s;

    // Measurement sequence
    case (r.st)
      ifsub_pkg::IFSUB_IDLE: begin
        if (i_count_start) begin
          r_nxt.st = ifsub_pkg::IFSUB_RUN;
          r_nxt.gate_cnt = gate_cycles(i_ctrl.gate_select);
          r_nxt.if_cnt = '0;
          r_nxt.done = 1'b0;
        end
      end
      ifsub_pkg::IFSUB_RUN: begin
        if (src_rise && r.if_cnt != '1) begin
          r_nxt.if_cnt = r.if_cnt + 21'h00_0001;
        end
        r_nxt.gate_cnt = r.gate_cnt - 23'h00_0001;
        if (r.gate_cnt <= 23'h00_0001) begin
          r_nxt.st = ifsub_pkg::IFSUB_DONE;
        end
      end
      ifsub_pkg::IFSUB_DONE: begin
        r_nxt.result = r.if_cnt;
        r_nxt.over = r.if_cnt >
          count_limit(i_ctrl.gate_select, i_ctrl.if_range_select);
        r_nxt.done = 1'b1;
        r_nxt.st = ifsub_pkg::IFSUB_IDLE;
      end
      default: begin
        r_nxt.st = ifsub_pkg::IFSUB_IDLE;
      end
    endcase

    // Prescaler and swallow counter
    if (!i_ctrl.sub_divider_enable) begin
      r_nxt.presc = 1'b0;
      r_nxt.sw_cnt = '0;
    end else if (lo_rise) begin
      r_nxt.presc = ~r.presc;
      if (pre_rise) begin
        r_nxt.sw_cnt = div_pulse ? '0 : r.sw_cnt + 13'h0001;
      end
    end

    // Phase frequency detector
    r_nxt.up = r.up | div_pulse;
    r_nxt.dn = r.dn | ref_rise;
    if ((r.up | div_pulse) && (r.dn | ref_rise)) begin
      r_nxt.up = 1'b0;
      r_nxt.dn = 1'b0;
    end
    if (!i_ctrl.sub_divider_enable) begin
      r_nxt.up = 1'b0;
      r_nxt.dn = 1'b0;
    end

    // Charge pump drive from the detector
    r_nxt.cp_out = r_nxt.up;
    r_nxt.cp_oe_n = ~(r_nxt.up ^ r_nxt.dn);

    // Offer a fresh word once the link has taken the last
    if (ack_s == r.req) begin
      r_nxt.word = make_word(i_ctrl.output_content_select,
        i_ctrl.second_input_function, b_s, r.over, r.result);
      r_nxt.req = ~r.req;
    end
  end

  // State register, frozen while the enable is low
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      r <= '0;
      r.cp_oe_n <= 1'b1;
    end else if (i_clk_en) begin
      r <= r_nxt;
    end
  end

  // Outputs
  assign o_sub_lo_pulldown = ~i_ctrl.sub_divider_enable;
  assign o_sub_charge_pump_out = r.cp_out;
  assign o_sub_charge_pump_oe_n = r.cp_oe_n;
  assign o_count_busy = (r.st == ifsub_pkg::IFSUB_RUN);
  assign o_count_done = r.done;
  assign o_count_over = r.over;
  assign o_count_result = r.result;
endmodule : ifsub_top

/* sim/ifsub_top_sva.sv */
// Checker of the top ports: gate timing, result hold, pump and serial idle.
// Assumes binding into ifsub_top with its gate parameters handed on.
`timescale 1ns/1ns
`include "ifsub_defs.svh"
module ifsub_top_sva #(
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE0_CYC = '0,
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE1_CYC = '0,
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE2_CYC = '0,
  parameter logic [`IFSUB_GATE_W-1:0] P_GATE3_CYC = '0
) (
  // Clocks, reset and controls
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_clk_en,
  input wire ifsub_pkg::ifsub_ctrl_t i_ctrl,
  input wire logic i_count_start,
  input wire logic i_serial_clock,
  input wire logic i_read_enable,
  // Watched outputs
  input wire logic o_serial_data,
  input wire logic o_sub_lo_pulldown,
  input wire logic o_sub_charge_pump_oe_n,
  input wire logic o_count_busy,
  input wire logic o_count_done,
  input wire logic [`IFSUB_CNT_W-1:0] o_count_result
);
  logic [`IFSUB_GATE_W-1:0] busy_cnt_r;
  logic [`IFSUB_GATE_W-1:0] gate_cyc;
  // Gate length of the selected period
  always_comb begin
    case (i_ctrl.gate_select)
      2'h0: gate_cyc = P_GATE0_CYC;
      2'h1: gate_cyc = P_GATE1_CYC;
      2'h2: gate_cyc = P_GATE2_CYC;
      default: gate_cyc = P_GATE3_CYC;
    endcase
  end
  // Counts the enabled cycles of the running gate
  always_ff @(posedge i_clk) begin
    if (!i_reset_n || !o_count_busy) begin
      busy_cnt_r <= '0;
    end else if (i_clk_en) begin
      busy_cnt_r <= busy_cnt_r + 1'b1;
    end
  end
  sequence s_gate_end;
    $fell(o_count_busy);
  endsequence
  sequence s_done_soon;
    ##[1:2] $rose(o_count_done);
  endsequence
  property p_done_after;
    @(posedge i_clk) disable iff (!i_reset_n) s_gate_end |-> s_done_soon;
  endproperty
  a_done_after: assert property (p_done_after) else $error("done late");
  property p_gate_len;
    @(posedge i_clk) disable iff (!i_reset_n) s_gate_end |-> busy_cnt_r == gate_cyc;
  endproperty
  a_gate_len: assert property (p_gate_len) else $error("gate length");
  property p_busy_start;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_count_busy) |-> $past(i_count_start) && !o_count_done;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy cause");
  property p_result_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_count_done && $past(o_count_done) |-> $stable(o_count_result);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result moved");
  property p_lo_pull;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_sub_lo_pulldown == !i_ctrl.sub_divider_enable;
  endproperty
  a_lo_pull: assert property (p_lo_pull) else $error("pulldown wrong");
  property p_pump_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_ctrl.sub_divider_enable [*2] |-> o_sub_charge_pump_oe_n;
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump driving");
  property p_pump_src;
    @(posedge i_clk) disable iff (!i_reset_n)
      !o_sub_charge_pump_oe_n |-> $past(i_ctrl.sub_divider_enable);
  endproperty
  a_pump_src: assert property (p_pump_src) else $error("pump cause");
  property p_sdata_idle;
    @(posedge i_serial_clock) disable iff (!i_reset_n) !i_read_enable |=> !o_serial_data;
  endproperty
  a_sdata_idle: assert property (p_sdata_idle) else $error("data outside frame");
endmodule : ifsub_top_sva

bind ifsub_top ifsub_top_sva #(.P_GATE0_CYC(P_GATE0_CYC), .P_GATE1_CYC(P_GATE1_CYC),
  .P_GATE2_CYC(P_GATE2_CYC), .P_GATE3_CYC(P_GATE3_CYC)) ifsub_top_sva_i (.*);

/* sim/ifsub_ctl_model.sv */
// Controller model: reads the serial word on a clock it runs only when needed.
// Assumes the bench raises i_req and waits for o_done.
`timescale 1ns/1ns
`include "ifsub_defs.svh"
module ifsub_ctl_model (
  // Bench side
  input wire logic i_reset_n,
  input wire logic i_req,
  output logic o_done,
  output logic [`IFSUB_WORD_W-1:0] o_word,
  // Serial bus
  output logic o_serial_clock,
  output logic o_read_enable,
  input wire logic i_serial_data
);
  // One 48 ns serial clock period
  task automatic tick;
    #24 o_serial_clock = 1'b1;
    #24 o_serial_clock = 1'b0;
  endtask : tick
  // Clock runs in reset and during reads only, stands low otherwise
  initial begin
    {o_serial_clock, o_read_enable, o_done, o_word} = '0;
    forever begin
      wait (!i_reset_n || i_req != o_done);
      if (!i_reset_n) begin
        tick();
      end else if (o_done) begin
        o_done = 1'b0;
      end else begin
        repeat (8) tick(); // Lead-in lets the fresh word cross
        o_read_enable = 1'b1;
        repeat (`IFSUB_WORD_W) begin
          tick(); // Bit taken at the falling edge, MSB first
          o_word = {o_word[`IFSUB_WORD_W-2:0], i_serial_data};
        end
        o_read_enable = 1'b0;
        tick();
        o_done = 1'b1;
      end
    end
  end
endmodule : ifsub_ctl_model

/* sim/ifsub_top_tb_top.sv */
// Bench: IF count paths, gate periods, serial word and sub pump.
// Assumes short gate parameters and the controller model on the link.
`timescale 1ns/1ns
`include "ifsub_defs.svh"
module ifsub_top_tb_top;
  localparam logic [`IFSUB_GATE_W-1:0] G0 = 23'h0028;
  localparam logic [`IFSUB_GATE_W-1:0] G1 = 23'h0050;
  localparam logic [`IFSUB_GATE_W-1:0] G2 = 23'h0140;
  localparam logic [`IFSUB_GATE_W-1:0] G3 = 23'h0280;
  logic i_clk, i_reset_n, i_clk_en, i_count_start, i_serial_clock, i_read_enable;
  logic i_if_input_a, i_if_input_b_or_port, i_sub_lo_input, i_sub_reference;
  logic o_serial_data, o_sub_lo_pulldown, o_sub_charge_pump_out, o_sub_charge_pump_oe_n;
  logic o_count_busy, o_count_done, o_count_over, req, done, b_run, b_lvl, lo_run, rf_run;
  logic [`IFSUB_CNT_W-1:0] o_count_result;
  logic [`IFSUB_WORD_W-1:0] word;
  logic [7:0] ph;
  ifsub_pkg::ifsub_ctrl_t i_ctrl;
  int gc[4] = '{G0, G1, G2, G3};
  int n_mismatch = 0;
  int cmp_count = 0;
  ifsub_top #(.P_GATE0_CYC(G0), .P_GATE1_CYC(G1), .P_GATE2_CYC(G2), .P_GATE3_CYC(G3))
    ifsub_top_i (.*);
  ifsub_ctl_model ifsub_ctl_model_i (.i_reset_n(i_reset_n), .i_req(req), .o_done(done),
    .o_word(word), .o_serial_clock(i_serial_clock), .o_read_enable(i_read_enable),
    .i_serial_data(o_serial_data));
  // Core clock
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // Pins: A at 25 MHz, B at 12.5 MHz or held, LO at 25 MHz, slow reference
  always @(posedge i_clk) begin
    ph <= ph + 8'h01;
    i_if_input_a <= ph[1];
    i_if_input_b_or_port <= b_run ? ph[2] : b_lvl;
    i_sub_lo_input <= lo_run & ph[1];
    i_sub_reference <= rf_run & ph[7];
  end
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask : chk
  // Count within one edge of the ideal, since pins are resynchronised
  function automatic bit near(input logic [`IFSUB_CNT_W-1:0] v, input int ex);
    return v === 21'(ex - 1) || v === 21'(ex) || v === 21'(ex + 1);
  endfunction : near
  task automatic summarize;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize
  task automatic run_src(input logic sel, input logic [1:0] g, input int ex);
    @(posedge i_clk);
    i_ctrl.counter_input_select <= sel;
    i_ctrl.gate_select <= g;
    i_count_start <= 1'b1;
    @(posedge i_clk);
    i_count_start <= 1'b0;
    repeat (3) @(negedge i_clk);
    for (int i = 0; i < 900 && o_count_done !== 1'b1; i++) @(negedge i_clk);
    chk(near(o_count_result, ex), "count value");
  endtask : run_src
  task automatic read_word;
    req = 1'b1;
    for (int i = 0; i < 300 && done !== 1'b1; i++) @(negedge i_clk);
    req = 1'b0;
    for (int i = 0; i < 30 && done !== 1'b0; i++) @(negedge i_clk);
  endtask : read_word
  task automatic t_gates;
    for (int g = 0; g < 4; g++) begin
      @(posedge i_clk);
      i_ctrl.if_range_select <= g[0];
      run_src(1'b0, g[1:0], gc[g] / 4);
      chk(o_count_over === 1'b0, "over flag");
    end
    read_word();
    chk(word[23:22] === 2'b00 && near(word[20:0], gc[3] / 4), "serial count");
  endtask : t_gates
  task automatic t_freeze;
    @(posedge i_clk);
    i_ctrl.counter_input_select <= 1'b0;
    i_ctrl.gate_select <= 2'h0;
    i_count_start <= 1'b1;
    @(posedge i_clk);
    i_count_start <= 1'b0;
    i_clk_en <= 1'b0;
    repeat (60) @(negedge i_clk);
    chk(o_count_busy === 1'b1 && o_count_done === 1'b0, "freeze");
    @(posedge i_clk);
    i_clk_en <= 1'b1;
    for (int i = 0; i < 200 && o_count_done !== 1'b1; i++) @(negedge i_clk);
    chk(near(o_count_result, G0 / 4), "count after freeze");
  endtask : t_freeze
  task automatic t_port;
    for (int l = 0; l < 2; l++) begin
      @(posedge i_clk);
      b_run <= 1'b0;
      b_lvl <= l[0];
      i_ctrl.second_input_function <= 1'b0;
      i_ctrl.output_content_select <= 3'h1;
      repeat (20) @(negedge i_clk);
      read_word();
      chk(word === {l[0], 23'h00_0000}, "port level");
    end
  endtask : t_port
  task automatic t_pump;
    @(posedge i_clk);
    lo_run <= 1'b1;
    i_ctrl.sub_divisor <= 13'h0110;
    i_ctrl.sub_divider_enable <= 1'b1;
    repeat (2100) @(negedge i_clk);
    chk(o_sub_charge_pump_oe_n === 1'b1 && o_sub_lo_pulldown === 1'b0, "early");
    repeat (150) @(negedge i_clk);
    chk(o_sub_charge_pump_oe_n === 1'b0 && o_sub_charge_pump_out === 1'b1, "up");
    @(posedge i_clk);
    lo_run <= 1'b0;
    rf_run <= 1'b1;
    repeat (700) @(negedge i_clk);
    chk(o_sub_charge_pump_oe_n === 1'b0 && o_sub_charge_pump_out === 1'b0, "down");
    @(posedge i_clk);
    i_ctrl.sub_divider_enable <= 1'b0;
    repeat (3) @(negedge i_clk);
    chk(o_sub_charge_pump_oe_n === 1'b1 && o_sub_lo_pulldown === 1'b1, "off");
  endtask : t_pump
  // Watchdog against a hang
  initial begin
    #400000;
    n_mismatch++;
    summarize();
  end
  // Main sequence
  initial begin
    i_ctrl = '0;
    i_ctrl.second_input_function = 1'b1;
    {i_reset_n, i_count_start, req, b_lvl, lo_run, rf_run, ph} = '0;
    {i_if_input_a, i_if_input_b_or_port, i_sub_lo_input, i_sub_reference} = '0;
    i_clk_en = 1'b1;
    b_run = 1'b1;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1'b1;
    @(negedge i_clk);
    chk(o_sub_charge_pump_oe_n === 1'b1 && o_count_done === 1'b0, "reset state");
    t_gates();
    $display("end gates");
    run_src(1'b1, 2'h1, G1 / 8);
    $display("end input b");
    t_freeze();
    $display("end freeze");
    t_port();
    $display("end port");
    t_pump();
    $display("end pump");
    summarize();
  end
endmodule : ifsub_top_tb_top
